// [cfg_loader_pkg.sv]
// Package for the nonvolatile default configuration loader.
// Assumes a single 100 MHz clock domain; bus pins are sampled asynchronously.
package cfg_loader_pkg;
    localparam logic [6:0] BUS_ID_BASE = 7'h28;
    localparam logic [7:0] ALERT_MASK_OFS = 8'h0c;
    localparam logic [7:0] PORT_CURRENT_OFS = 8'h18;
    localparam logic [7:0] CABLE_LIMIT_OFS = 8'h1e;
    localparam logic [7:0] CABLE_WATCH_OFS = 8'h20;
    localparam logic [7:0] BUS_WINDOW_OFS = 8'h22;
    localparam logic [7:0] RESET_SOURCE_OFS = 8'h23;
    localparam logic [7:0] DRAIN_TIME_OFS = 8'h25;
    localparam logic [7:0] PORT_ROLE_OFS = 8'h28;
    localparam logic [7:0] SUPPLY_CHECK_OFS = 8'h2e;
    // Factory defaults of the fields that live in registers
    localparam logic [2:0] ALERT_MASK_DEF = 3'h7;
    localparam logic [1:0] OFFERED_CURRENT_DEF = 2'h1;
    localparam logic CABLE_DRAIN_DEF = 1'b0;
    localparam logic CABLE_SUPPLY_DEF = 1'b1;
    localparam logic [3:0] CABLE_LIMIT_DEF = 4'h0;
    localparam logic CABLE_WATCH_DEF = 1'b1;
    localparam logic CABLE_LOW_SEL_DEF = 1'b0;
    localparam logic [3:0] BUS_UPPER_DEF = 4'h5;
    localparam logic [3:0] BUS_LOWER_DEF = 4'h5;
    localparam logic SOFT_RESTART_DEF = 1'b0;
    localparam logic [3:0] DRAIN_FULL_DEF = 4'ha;
    localparam logic [3:0] DRAIN_STEP_DEF = 4'ha;
    localparam logic [2:0] PORT_ROLE_DEF = 3'h3;
    localparam logic MAIN_HIGH_INH_DEF = 1'b0;
    localparam logic WINDOW_INH_DEF = 1'b0;
    localparam logic [1:0] ZERO_LEVEL_DEF = 2'h0;
    localparam logic MAIN_LOW_INH_DEF = 1'b1;
    // Nonvolatile-only defaults
    localparam logic STANDBY_INH_DEF = 1'b1;
    localparam logic BUS_DRAIN_INH_DEF = 1'b0;
    // Password that unlocks the single reprogramming; value arbitrary
    localparam logic [31:0] PROGRAM_KEY = 32'h5a3c_96e1;

    // Nonvolatile image: one record of all fields that can be preset
    typedef struct packed {
        logic [2:0] alert_mask;
        logic [1:0] offered_current_level;
        logic cable_supply_drain_enable;
        logic cable_supply_enable;
        logic [3:0] cable_supply_current_limit;
        logic [3:0] bus_upper_bound_offset;
        logic [3:0] bus_lower_bound_offset;
        logic [3:0] bus_drain_full_time;
        logic [3:0] bus_drain_step_time;
        logic [2:0] port_role_select;
        logic main_supply_high_check_inhibit;
        logic bus_window_check_inhibit;
        logic [1:0] bus_zero_level_select;
        logic main_supply_low_check_inhibit;
        logic standby_inhibit;
        logic bus_drain_inhibit;
    } nvm_image_t;

    localparam nvm_image_t NVM_FACTORY = '{
        alert_mask: ALERT_MASK_DEF,
        offered_current_level: OFFERED_CURRENT_DEF,
        cable_supply_drain_enable: CABLE_DRAIN_DEF,
        cable_supply_enable: CABLE_SUPPLY_DEF,
        cable_supply_current_limit: CABLE_LIMIT_DEF,
        bus_upper_bound_offset: BUS_UPPER_DEF,
        bus_lower_bound_offset: BUS_LOWER_DEF,
        bus_drain_full_time: DRAIN_FULL_DEF,
        bus_drain_step_time: DRAIN_STEP_DEF,
        port_role_select: PORT_ROLE_DEF,
        main_supply_high_check_inhibit: MAIN_HIGH_INH_DEF,
        bus_window_check_inhibit: WINDOW_INH_DEF,
        bus_zero_level_select: ZERO_LEVEL_DEF,
        main_supply_low_check_inhibit: MAIN_LOW_INH_DEF,
        standby_inhibit: STANDBY_INH_DEF,
        bus_drain_inhibit: BUS_DRAIN_INH_DEF
    };

    // Live settings presented to the rest of the port controller
    typedef struct packed {
        nvm_image_t preset;
        logic cable_supply_watch_enable;
        logic cable_supply_low_level_select;
        logic soft_restart_select;
    } live_cfg_t;
endpackage : cfg_loader_pkg

// [nvm_default_config_loader.sv]
// Configuration store with serial slave write port and nonvolatile defaults.
// Assumes scl/sda come from an open-drain bus outside the clock domain and
// that the nonvolatile image survives rstn (held in the same flops here).
`timescale 1ns/1ps

// Behaviour
// R01: Write: address+W, register address, data bytes to n, n+1, ...; each acked.
// R02: Slave only; any bus clock up to 400 kHz is accepted.
// R03: After reset every preset field reloads from the nonvolatile image.
// R04: Image may be reprogrammed once, only with the correct password.
// R05: Software values hold until overwritten or reset, then revert to defaults.
// R06: Software-only, nonvolatile-only and both kinds enforce their own writability.
// R07: Register 0x0c alert mask bits default to 1 (masked).
// R08: Standby inhibit is nonvolatile-only and defaults to 1.
// R09: Port role select in 0x28 defaults to 011b.
// R10: 0x18 defaults current 01b, drain 0, supply 1; 0x1e limit 0000b.
// R11: 0x20 software-only watch enable 1, low-level select 0.
// R12: 0x22 upper and lower bound offsets both default to 0101b.
// R13: 0x23 soft restart select defaults to 0.
// R14: 0x25 drain time fields both default to 1010b.
// R15: Bus drain inhibit is nonvolatile-only and defaults to 0.
// R16: 0x2e defaults 0, 0, 00b, 1.
// R17: Answers to bus address 0x28 or 0x29 chosen by strap pin.
// R18: Bytes shift most significant bit first.
module nvm_default_config_loader
    import cfg_loader_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic bus_id_strap,
    input wire logic program_req,
    input wire logic [31:0] program_key,
    input wire nvm_image_t program_image,
    output logic program_done,
    output logic program_refused,
    output live_cfg_t cfg
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SHIFT = 5'b00010,
        ST_ACK = 5'b00100,
        ST_ACK_END = 5'b01000,
        ST_IGNORE = 5'b10000
    } link_state_t;

    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_q;
    logic sda_q;
    logic [6:0] bus_id;
    link_state_t state;
    logic [7:0] shreg;
    logic [2:0] bit_cnt;
    logic [1:0] phase;
    logic [7:0] reg_addr;
    logic wr_pulse;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    // Power-up values stand in for the store's contents; rstn never touches them
    nvm_image_t nvm = NVM_FACTORY;
    logic nvm_used = 1'b0;

    wire scl_rise = scl_sync[1] & ~scl_q;
    wire scl_fall = ~scl_sync[1] & scl_q;
    wire start_seen = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
    wire stop_seen = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
    wire [7:0] next_byte = {shreg[6:0], sda_sync[1]};

    // Two flops on each pin; the 100 MHz clock oversamples bus clocks up to 400 kHz [R02]
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_q <= scl_sync[1];
            sda_q <= sda_sync[1];
        end
    end

    // Strap is caught on every clock while reset is held, frozen afterwards [R17]
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus_id <= {BUS_ID_BASE[6:1], bus_id_strap};
        end
    end

    // Slave-only byte engine; phase 0 = device address, 1 = register, 2 = data [R01]
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= ST_IDLE;
            shreg <= 8'h00;
            bit_cnt <= 3'h0;
            phase <= 2'h0;
            reg_addr <= 8'h00;
            wr_pulse <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            wr_pulse <= 1'b0;
            if (start_seen) begin
                state <= ST_SHIFT;
                bit_cnt <= 3'h0;
                phase <= 2'h0;
                sda_oe <= 1'b0;
            end else if (stop_seen) begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    ST_SHIFT: begin
                        if (scl_rise) begin
                            shreg <= next_byte; // [R18]
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                state <= ST_ACK;
                                if (phase == 2'h0) begin
                                    // Reads are outside this block; only write is acked
                                    if (next_byte != {bus_id, 1'b0}) begin // [R17]
                                        state <= ST_IGNORE;
                                    end
                                end else if (phase == 2'h1) begin
                                    reg_addr <= next_byte;
                                end else begin
                                    wr_pulse <= 1'b1;
                                    wr_addr <= reg_addr;
                                    wr_data <= next_byte;
                                    reg_addr <= reg_addr + 8'h01; // [R01]
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        // Drive low only after scl falls so data hold is respected
                        if (scl_fall) begin
                            sda_oe <= 1'b1; // [R01]
                            state <= ST_ACK_END;
                        end
                    end
                    ST_ACK_END: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            state <= ST_SHIFT;
                            if (phase != 2'h2) begin
                                phase <= phase + 2'h1;
                            end
                        end
                    end
                    ST_IGNORE: begin
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        state <= ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Nonvolatile image: not touched by rstn, so a reset reloads it [R03]
    always_ff @(posedge clk) begin
        if (program_req && !nvm_used && program_key == PROGRAM_KEY) begin
            nvm <= program_image; // [R04]
        end
    end

    // One-time programming lock; a power cycle in silicon keeps it, rstn here does too
    always_ff @(posedge clk) begin
        if (!rstn) begin
            program_done <= 1'b0;
            program_refused <= 1'b0;
        end else if (program_req) begin
            if (!nvm_used && program_key == PROGRAM_KEY) begin
                program_done <= 1'b1; // [R04]
                program_refused <= 1'b0;
            end else begin
                program_done <= 1'b0;
                program_refused <= 1'b1; // [R04]
            end
        end else begin
            program_done <= 1'b0;
            program_refused <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (program_req && !nvm_used && program_key == PROGRAM_KEY) begin
            nvm_used <= 1'b1; // [R04]
        end
    end

    // Live registers: reload image on reset, then follow bus writes [R03] [R05]
    always_ff @(posedge clk) begin
        if (!rstn) begin
            // Standby and drain inhibit reach cfg only through the image [R08] [R15]
            cfg.preset <= nvm; // [R03]
            cfg.cable_supply_watch_enable <= CABLE_WATCH_DEF; // [R11]
            cfg.cable_supply_low_level_select <= CABLE_LOW_SEL_DEF; // [R11]
            cfg.soft_restart_select <= SOFT_RESTART_DEF; // [R13]
        end else if (wr_pulse) begin
            // Standby and drain inhibit have no address: unreachable by the bus [R06]
            case (wr_addr)
                ALERT_MASK_OFS: cfg.preset.alert_mask <= wr_data[2:0]; // [R07]
                PORT_CURRENT_OFS: begin
                    cfg.preset.offered_current_level <= wr_data[1:0]; // [R10]
                    cfg.preset.cable_supply_drain_enable <= wr_data[2];
                    cfg.preset.cable_supply_enable <= wr_data[3];
                end
                CABLE_LIMIT_OFS: cfg.preset.cable_supply_current_limit <= wr_data[3:0];
                CABLE_WATCH_OFS: begin
                    cfg.cable_supply_watch_enable <= wr_data[0]; // [R11]
                    cfg.cable_supply_low_level_select <= wr_data[1];
                end
                BUS_WINDOW_OFS: begin
                    cfg.preset.bus_lower_bound_offset <= wr_data[3:0]; // [R12]
                    cfg.preset.bus_upper_bound_offset <= wr_data[7:4];
                end
                RESET_SOURCE_OFS: cfg.soft_restart_select <= wr_data[0]; // [R13]
                DRAIN_TIME_OFS: begin
                    cfg.preset.bus_drain_step_time <= wr_data[3:0]; // [R14]
                    cfg.preset.bus_drain_full_time <= wr_data[7:4];
                end
                PORT_ROLE_OFS: cfg.preset.port_role_select <= wr_data[2:0]; // [R09]
                SUPPLY_CHECK_OFS: begin
                    cfg.preset.main_supply_high_check_inhibit <= wr_data[0]; // [R16]
                    cfg.preset.bus_window_check_inhibit <= wr_data[1];
                    cfg.preset.bus_zero_level_select <= wr_data[3:2];
                    cfg.preset.main_supply_low_check_inhibit <= wr_data[4];
                end
                default: begin
                    // Unmapped addresses are acked and dropped [R06]
                end
            endcase
        end
    end
endmodule : nvm_default_config_loader

// [cfg_loader_props.sv]
// Checker for the configuration loader, bound to its top-level ports.
// Assumes the nonvolatile image starts as the factory image at time zero.
`timescale 1ns/1ps
module cfg_loader_props
    import cfg_loader_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic bus_id_strap,
    input wire logic program_req,
    input wire logic [31:0] program_key,
    input wire nvm_image_t program_image,
    input wire logic program_done,
    input wire logic program_refused,
    input wire live_cfg_t cfg
);
    // Shadow image survives reset, as the store does
    nvm_image_t image_q = NVM_FACTORY;
    nvm_image_t pend_q;
    logic used_q = 1'b0;
    always_ff @(posedge clk) begin
        if (program_req) pend_q <= program_image;
    end
    always_ff @(posedge clk) begin
        if (program_done) begin
            image_q <= pend_q;
            used_q <= 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence ack_pulse;
        sda_oe [*8];
    endsequence
    sequence soft_defaults;
        cfg.cable_supply_watch_enable && !cfg.cable_supply_low_level_select
            && !cfg.soft_restart_select;
    endsequence
    chk_prog_answer: assert property (program_req |=> program_done != program_refused)
        else $error("program request not answered once");
    chk_key_refused: assert property (
        program_req && program_key != PROGRAM_KEY |=> program_refused)
        else $error("wrong key not refused");
    chk_prog_once: assert property (program_done |-> !used_q)
        else $error("image accepted a second time");
    chk_image_reload: assert property ($rose(rstn) |-> cfg.preset == image_q)
        else $error("image not reloaded at reset");
    chk_soft_defaults: assert property ($rose(rstn) |-> soft_defaults)
        else $error("software-only fields not at defaults");
    chk_ack_shape: assert property ($rose(sda_oe) |-> !scl_in ##0 ack_pulse)
        else $error("acknowledge not held through its bit");
    chk_ack_release: assert property ($rose(sda_oe) |-> ##[8:30] !sda_oe)
        else $error("acknowledge never released");
    chk_pull_low: assert property (sda_oe |-> !sda_out)
        else $error("data driven high");
endmodule : cfg_loader_props

bind nvm_default_config_loader cfg_loader_props u_props (.clk(clk), .rstn(rstn),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .bus_id_strap(bus_id_strap), .program_req(program_req), .program_key(program_key),
    .program_image(program_image), .program_done(program_done),
    .program_refused(program_refused), .cfg(cfg));

// [i2c_host_model.sv]
// Bus master model writing registers over the two-wire serial bus.
// Assumes an open-drain data wire with a pull-up, resolved by the bench.
`timescale 1ns/1ps
module i2c_host_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // Quarter of the 125 ns bus clock; the clock stands high outside frames
    localparam realtime Q = 31.25;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic start();
        sda_low = 1'b1; // Falls while the clock is high
        #(2 * Q);
        scl = 1'b0;
        #Q;
    endtask : start
    task automatic bit_io(input logic b, output logic seen);
        sda_low = !b; // Data moves only while the clock is low
        #Q;
        scl = 1'b1;
        #Q;
        seen = sda;
        #Q;
        scl = 1'b0;
        #Q;
    endtask : bit_io
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask : send
    task automatic stop();
        sda_low = 1'b1;
        #Q;
        scl = 1'b1;
        #Q;
        sda_low = 1'b0; // Rises while the clock is high
        #(4 * Q);
    endtask : stop
endmodule : i2c_host_model

// [tb.sv]
// Self-checking bench for the configuration loader.
// Assumes the host model owns the serial bus; all other inputs are driven here.
`timescale 1ns/1ps
module tb;
    import cfg_loader_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic bus_id_strap = 1'b0;
    logic program_req = 1'b0;
    logic [31:0] program_key = 32'h0;
    nvm_image_t program_image = NVM_FACTORY;
    nvm_image_t nv = NVM_FACTORY;
    logic sda_out, sda_oe, program_done, program_refused, scl, host_low;
    live_cfg_t cfg, exp;
    logic [7:0] seed = 8'h3d;
    logic [7:0] regs [7] = '{8'h0c, 8'h18, 8'h1e, 8'h20, 8'h22, 8'h28, 8'h2e};
    int fail_count = 0;
    int n_compared = 0;
    wire sda = (host_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    always #5 clk = ~clk;
    i2c_host_model host (.scl(scl), .sda_low(host_low), .sda(sda));
    nvm_default_config_loader dut (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .bus_id_strap(bus_id_strap),
        .program_req(program_req), .program_key(program_key), .program_image(program_image),
        .program_done(program_done), .program_refused(program_refused), .cfg(cfg));
    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction : rnd
    function automatic live_cfg_t apply(live_cfg_t c, logic [7:0] r, logic [7:0] v);
        case (r)
            8'h0c: c.preset.alert_mask = v[2:0];
            8'h18: {c.preset.cable_supply_enable, c.preset.cable_supply_drain_enable,
                c.preset.offered_current_level} = v[3:0];
            8'h1e: c.preset.cable_supply_current_limit = v[3:0];
            8'h20: {c.cable_supply_low_level_select, c.cable_supply_watch_enable} = v[1:0];
            8'h22: {c.preset.bus_upper_bound_offset, c.preset.bus_lower_bound_offset} = v;
            8'h23: c.soft_restart_select = v[0];
            8'h25: {c.preset.bus_drain_full_time, c.preset.bus_drain_step_time} = v;
            8'h28: c.preset.port_role_select = v[2:0];
            8'h2e: {c.preset.main_supply_low_check_inhibit, c.preset.bus_zero_level_select,
                c.preset.bus_window_check_inhibit,
                c.preset.main_supply_high_check_inhibit} = v[4:0];
            default: ;
        endcase
        return c;
    endfunction : apply
    task automatic chk(string n, logic [63:0] e, logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic rst(logic s);
        @(negedge clk);
        rstn = 1'b0;
        bus_id_strap = s;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        exp = {nv, 3'h4};
        chk("cfg after reset", exp, cfg);
    endtask : rst
    task automatic wr(logic [7:0] ab, logic [7:0] r, int n, logic [7:0] d[4]);
        logic k;
        logic m;
        int acks;
        acks = 0;
        m = (ab == {7'h28 + 7'(bus_id_strap), 1'h0});
        host.start();
        host.send(ab, k);
        acks += k;
        if (k) begin
            host.send(r, k);
            acks += k;
            for (int i = 0; i < n; i++) begin
                host.send(d[i], k);
                acks += k;
            end
        end
        host.stop();
        chk("acks", m ? 2 + n : 0, acks);
        for (int i = 0; i < n && m; i++) exp = apply(exp, r + 8'(i), d[i]);
    endtask : wr
    task automatic prog(logic [31:0] key, logic ok);
        logic [39:0] t;
        t = {rnd(), rnd(), rnd(), rnd(), rnd()};
        @(negedge clk);
        program_req = 1'b1;
        program_key = key;
        program_image = t[$bits(nvm_image_t)-1:0];
        @(negedge clk);
        chk("program answer", {ok, !ok}, {program_done, program_refused});
        program_req = 1'b0;
        @(negedge clk);
        if (ok) nv = program_image;
    endtask : prog
    initial begin
        logic [7:0] d[4];
        rst(1'h0);
        chk("alert masks", 3'h7, cfg.preset.alert_mask);
        chk("standby", 1'h1, cfg.preset.standby_inhibit);
        chk("role", 3'h3, cfg.preset.port_role_select);
        chk("0x18 0x1e", 8'h50, {cfg.preset.offered_current_level,
            cfg.preset.cable_supply_drain_enable, cfg.preset.cable_supply_enable,
            cfg.preset.cable_supply_current_limit});
        chk("0x20", 2'h2, {cfg.cable_supply_watch_enable, cfg.cable_supply_low_level_select});
        chk("0x22", 8'h55, {cfg.preset.bus_upper_bound_offset, cfg.preset.bus_lower_bound_offset});
        chk("0x23", 1'h0, cfg.soft_restart_select);
        chk("0x25", 8'haa, {cfg.preset.bus_drain_full_time, cfg.preset.bus_drain_step_time});
        chk("drain inhibit", 1'h0, cfg.preset.bus_drain_inhibit);
        chk("0x2e", 5'h10, {cfg.preset.main_supply_low_check_inhibit,
            cfg.preset.bus_zero_level_select, cfg.preset.bus_window_check_inhibit,
            cfg.preset.main_supply_high_check_inhibit});
        repeat (3) begin
            foreach (regs[i]) begin
                foreach (d[j]) d[j] = rnd();
                // The burst from 0x22 also crosses the unmapped 0x24
                wr({7'h28, 1'h0}, regs[i], regs[i] == 8'h22 ? 4 : 1, d);
            end
            chk("cfg after writes", exp, cfg);
        end
        wr({7'h29, 1'h0}, 8'h28, 1, d);
        wr({7'h28, 1'h1}, 8'h28, 1, d);
        chk("cfg untouched", exp, cfg);
        rst(1'h0);
        prog(32'h0, 1'h0);
        prog(PROGRAM_KEY, 1'h1);
        prog(PROGRAM_KEY, 1'h0);
        rst(1'h1);
        wr({7'h29, 1'h0}, 8'h0c, 1, d);
        wr({7'h28, 1'h0}, 8'h2e, 1, d);
        chk("cfg with strap high", exp, cfg);
        test_done();
    end
    initial begin
        #300000;
        fail_count++;
        test_done();
    end
endmodule : tb
